// >>> inc/adcc_map.svh
/*
  Constant map of the second control word of the converter: bit positions,
  reset values, threshold table and timing counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ----------------------------------------------------------------
// Word select and bit positions
// ----------------------------------------------------------------
`define ADCC_SEL_HI 11
`define ADCC_SEL_LO 10
`define ADCC_SEL_CODE 2'h1
`define ADCC_BIT_DEVRST 0
`define ADCC_BIT_FIFOCLR 1
`define ADCC_BIT_THR_LO 2
`define ADCC_BIT_THR_HI 3
`define ADCC_BIT_TYPE 4
`define ADCC_BIT_POL 5
`define ADCC_BIT_RW 6
`define ADCC_BIT_FMT 7
`define ADCC_BIT_OFS 8
`define ADCC_BIT_RSV 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCC_RST_THR 2'h0
`define ADCC_RST_TYPE 1'h1
`define ADCC_RST_POL 1'h1
`define ADCC_RST_RW 1'h0
`define ADCC_RST_FMT 1'h0

// ----------------------------------------------------------------
// Threshold table, one channel then two channels
// ----------------------------------------------------------------
`define ADCC_THR1_0 5'h01
`define ADCC_THR1_1 5'h04
`define ADCC_THR1_2 5'h08
`define ADCC_THR1_3 5'h0E
`define ADCC_THR2_0 5'h02
`define ADCC_THR2_1 5'h04
`define ADCC_THR2_2 5'h08
`define ADCC_THR2_3 5'h0C

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define ADCC_HOLDOFF_CYCLES 3'h5
`define ADCC_FIFO_DEPTH 16
`define ADCC_SAMPLE_W 10

`endif

// >>> inc/adcc_pkg.sv
/*
  Types of the second control word block: control fields, pin group and
  trigger states.
  Assumes the constant map header is on the include path.
*/
`include "adcc_map.svh"

package adcc_pkg;

  // ----------------------------------------------------------------
  // Stored control fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] thresholdSel;
    logic pulseType;
    logic polarityHigh;
    logic combinedRw;
    logic resultFormatSel;
  } adcc_ctrl_t;

  // Host strobe pins and conversion clock, as one group
  typedef struct packed {
    logic cs0N;
    logic cs1;
    logic rdN;
    logic wrN;
    logic convClk;
  } adcc_pins_t;

  // Trigger sequencing
  typedef enum logic [1:0] {
    TRG_WAIT,
    TRG_ACTIVE,
    TRG_DRAIN
  } adcc_trig_t;

endpackage

// >>> src/adcc_fifo_mem.sv
/*
  Sample store of the FIFO: simple dual port array with registered read.
  Assumes pointers and fill are kept by the instantiating module.
*/
`timescale 1ns/1ns

module adcc_fifo_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array write
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// >>> src/adcc_ctrl_one.sv
/*
  Second control word of the dual input converter: host strobe decode,
  device and FIFO clear commands, offset calibration, sample buffering,
  FIFO with trigger threshold and the samples-ready output.
  Assumes host pins are asynchronous and synchronised here, and that the
  conversion pipeline and control word zero logic run on clk.
*/
`timescale 1ns/1ns
`include "adcc_map.svh"

module adcc_ctrl_one
  import adcc_pkg::*;
#(
  parameter int SW = `ADCC_SAMPLE_W,
  parameter int DEPTH = `ADCC_FIFO_DEPTH,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs0N,
  input wire logic cs1,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [11:0] busIn,
  output logic [SW-1:0] busOut,
  output logic busOe,
  input wire logic conversionClockIn,
  input wire logic twoChannels,
  input wire logic [SW-1:0] convSample,
  input wire logic convValid,
  output logic convReady,
  output logic offsetZeroReq,
  output logic devResetPulse,
  output logic samplesReadyOut
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  adcc_pins_t pinsMeta, pinsSync;
  logic [11:0] busMeta, busSync;
  logic convClkD;
  logic readActD, writeActD;

  // Two stages for every asynchronous pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinsMeta <= '{cs0N: 1'b1, cs1: 1'b0, rdN: 1'b1, wrN: 1'b1, convClk: 1'b0};
      pinsSync <= '{cs0N: 1'b1, cs1: 1'b0, rdN: 1'b1, wrN: 1'b1, convClk: 1'b0};
      busMeta <= 12'h000;
      busSync <= 12'h000;
    end else begin
      pinsMeta <= '{cs0N: cs0N, cs1: cs1, rdN: rdN, wrN: wrN, convClk: conversionClockIn};
      pinsSync <= pinsMeta;
      busMeta <= busIn;
      busSync <= busMeta;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adcc_ctrl_t ctrl, next_ctrl;
  adcc_trig_t trig, next_trig;
  logic [SW-1:0] offsetVal, next_offsetVal;
  logic calPending, next_calPending;
  logic [2:0] holdCnt, next_holdCnt;
  logic [SW-1:0] buf0, buf1, next_buf0, next_buf1;
  logic [1:0] bufCnt, next_bufCnt;
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] fifoCnt, next_fifoCnt;
  logic [AW:0] thresholdCount, readsLeft, next_readsLeft;
  logic readPend, next_readPend;
  logic pulseOn, next_pulseOn, pulseArm, next_pulseArm;
  logic [SW-1:0] next_busOut, memRdData;
  logic next_busOe, next_convReady, next_offsetZeroReq;
  logic next_devResetPulse, next_samplesReadyOut;

  logic chipSel, readAct, writeAct, readStart, writeStart, ctrlWrite;
  logic devRst, fifoClr, convEdge, convRise, push, pop, accept;
  logic [SW-1:0] corrected;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  // Chip selected when both selects valid
  assign chipSel = !pinsSync.cs0N && pinsSync.cs1;
  // Combined mode: write pin high reads, low writes; read pin ignored
  assign readAct = chipSel && (ctrl.combinedRw ? pinsSync.wrN
                   : (!pinsSync.rdN && pinsSync.wrN));
  assign writeAct = chipSel && (ctrl.combinedRw ? !pinsSync.wrN
                    : (!pinsSync.wrN && pinsSync.rdN));
  assign readStart = readAct && !readActD;
  assign writeStart = writeAct && !writeActD;
  // Only the 01 word select reaches this word
  assign ctrlWrite = writeStart
                     && busSync[`ADCC_SEL_HI:`ADCC_SEL_LO] == `ADCC_SEL_CODE;
  // Commands act only when written as one
  assign devRst = ctrlWrite && busSync[`ADCC_BIT_DEVRST];
  assign fifoClr = ctrlWrite && busSync[`ADCC_BIT_FIFOCLR];
  assign convEdge = pinsSync.convClk != convClkD;
  assign convRise = pinsSync.convClk && !convClkD;

  // ----------------------------------------------------------------
  // Datapath terms
  // ----------------------------------------------------------------
  // Offset removal, clamped at zero on the binary scale
  assign corrected = (convSample > offsetVal) ? convSample - offsetVal : '0;
  assign accept = convValid && convReady;
  assign push = bufCnt != 2'h0 && fifoCnt != (AW+1)'(DEPTH);
  assign pop = readStart && fifoCnt != '0;

  // Threshold by channel count; a differential pair is one channel
  always_comb begin
    thresholdCount = `ADCC_THR1_0;
    if (twoChannels) begin
      unique case (ctrl.thresholdSel)
        2'h0: thresholdCount = `ADCC_THR2_0;
        2'h1: thresholdCount = `ADCC_THR2_1;
        2'h2: thresholdCount = `ADCC_THR2_2;
        2'h3: thresholdCount = `ADCC_THR2_3;
      endcase
    end else begin
      unique case (ctrl.thresholdSel)
        2'h0: thresholdCount = `ADCC_THR1_0;
        2'h1: thresholdCount = `ADCC_THR1_1;
        2'h2: thresholdCount = `ADCC_THR1_2;
        2'h3: thresholdCount = `ADCC_THR1_3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_trig = trig;
    next_offsetVal = offsetVal;
    next_calPending = calPending;
    next_holdCnt = holdCnt;
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_bufCnt = bufCnt;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_fifoCnt = fifoCnt;
    next_readsLeft = readsLeft;
    next_readPend = pop;
    next_pulseOn = pulseOn;
    next_pulseArm = pulseArm;
    next_busOut = busOut;
    next_devResetPulse = devRst;

    // Field updates; read-backs never return this word
    if (ctrlWrite) begin
      next_ctrl.thresholdSel = busSync[`ADCC_BIT_THR_HI:`ADCC_BIT_THR_LO];
      next_ctrl.pulseType = busSync[`ADCC_BIT_TYPE];
      next_ctrl.polarityHigh = busSync[`ADCC_BIT_POL];
      next_ctrl.combinedRw = busSync[`ADCC_BIT_RW];
      next_ctrl.resultFormatSel = busSync[`ADCC_BIT_FMT];
      if (busSync[`ADCC_BIT_OFS]) begin
        next_calPending = 1'b1;
      end
    end

    // Start-up holdoff counted in conversion clock periods
    if (convRise && holdCnt != `ADCC_HOLDOFF_CYCLES) begin
      next_holdCnt = holdCnt + 3'h1;
    end

    // Two-entry buffer: fill from pipeline, drain into FIFO
    if (push) begin
      next_buf0 = buf1;
    end
    next_bufCnt = bufCnt - {1'b0, push};
    if (accept && holdCnt == `ADCC_HOLDOFF_CYCLES) begin
      if (calPending) begin
        next_offsetVal = convSample;
        next_calPending = ctrlWrite && busSync[`ADCC_BIT_OFS]; // New request wins
      end else begin
        if (next_bufCnt == 2'h0) begin
          next_buf0 = corrected;
        end else begin
          next_buf1 = corrected;
        end
        next_bufCnt = next_bufCnt + 2'h1;
      end
    end

    // FIFO pointers
    if (push) begin
      next_wrPtr = wrPtr + AW'(1);
    end
    if (pop) begin
      next_rdPtr = rdPtr + AW'(1);
    end
    next_fifoCnt = fifoCnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Output word formatted one cycle after the pop
    if (readPend) begin
      next_busOut = ctrl.resultFormatSel ? memRdData
                    : {~memRdData[SW-1], memRdData[SW-2:0]};
    end

    // Trigger sequencing, rearmed after the threshold count of reads
    unique case (trig)
      TRG_WAIT: begin
        if (fifoCnt >= thresholdCount) begin
          next_trig = TRG_ACTIVE;
          next_readsLeft = thresholdCount;
          next_pulseArm = ctrl.pulseType;
        end
      end
      TRG_ACTIVE, TRG_DRAIN: begin
        if (pop) begin
          next_readsLeft = readsLeft - (AW+1)'(1);
          next_trig = (readsLeft == (AW+1)'(1)) ? TRG_WAIT : TRG_DRAIN;
        end
      end
    endcase
    // Armed pulse rises on one conversion clock transition, falls on the next
    if (convEdge) begin
      next_pulseOn = pulseArm;
      next_pulseArm = next_pulseArm && !pulseArm;
    end

    // FIFO clear touches only the FIFO, the two-entry buffer and the trigger
    if (fifoClr || devRst) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_fifoCnt = '0;
      next_bufCnt = 2'h0;
      next_trig = TRG_WAIT;
      next_readsLeft = '0;
      next_pulseOn = 1'b0;
      next_pulseArm = 1'b0;
    end

    // Device reset restores fields, offset and start-up delay
    if (devRst) begin
      next_ctrl = '{thresholdSel: `ADCC_RST_THR, pulseType: `ADCC_RST_TYPE,
                    polarityHigh: `ADCC_RST_POL, combinedRw: `ADCC_RST_RW,
                    resultFormatSel: `ADCC_RST_FMT};
      next_offsetVal = '0;
      next_calPending = 1'b0;
      next_holdCnt = 3'h0;
    end

    // Registered outputs
    next_busOe = readAct;
    next_convReady = next_bufCnt != 2'h2;
    next_offsetZeroReq = next_calPending;
    // Level follows the active state, pulse follows its timer
    next_samplesReadyOut = (next_ctrl.pulseType ? next_pulseOn
                            : next_trig == TRG_ACTIVE) ~^ next_ctrl.polarityHigh;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '{thresholdSel: `ADCC_RST_THR, pulseType: `ADCC_RST_TYPE,
                polarityHigh: `ADCC_RST_POL, combinedRw: `ADCC_RST_RW,
                resultFormatSel: `ADCC_RST_FMT};
      trig <= TRG_WAIT;
      offsetVal <= '0;
      calPending <= 1'b0;
      holdCnt <= 3'h0;
      buf0 <= '0;
      buf1 <= '0;
      bufCnt <= 2'h0;
      wrPtr <= '0;
      rdPtr <= '0;
      fifoCnt <= '0;
      readsLeft <= '0;
      readPend <= 1'b0;
      pulseOn <= 1'b0;
      pulseArm <= 1'b0;
      convClkD <= 1'b0;
      readActD <= 1'b0;
      writeActD <= 1'b0;
      busOut <= '0;
      busOe <= 1'b0;
      convReady <= 1'b1;
      offsetZeroReq <= 1'b0;
      devResetPulse <= 1'b0;
      samplesReadyOut <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      trig <= next_trig;
      offsetVal <= next_offsetVal;
      calPending <= next_calPending;
      holdCnt <= next_holdCnt;
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      bufCnt <= next_bufCnt;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fifoCnt <= next_fifoCnt;
      readsLeft <= next_readsLeft;
      readPend <= next_readPend;
      pulseOn <= next_pulseOn;
      pulseArm <= next_pulseArm;
      convClkD <= pinsSync.convClk;
      readActD <= readAct;
      writeActD <= writeAct;
      busOut <= next_busOut;
      busOe <= next_busOe;
      convReady <= next_convReady;
      offsetZeroReq <= next_offsetZeroReq;
      devResetPulse <= next_devResetPulse;
      samplesReadyOut <= next_samplesReadyOut;
    end
  end

  // ----------------------------------------------------------------
  // Sample store
  // ----------------------------------------------------------------
  adcc_fifo_mem #(
    .WIDTH(SW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .wrEn(push),
    .wrAddr(wrPtr),
    .wrData(buf0),
    .rdAddr(rdPtr),
    .rdData(memRdData)
  );

endmodule

// >>> tb/adcc_ctrl_one_assertions.sv
/*
  Checker of the second control word block, bound to its top module.
  Assumes host pins held for several clocks per access.
*/
`timescale 1ns/1ns

module adcc_ctrl_one_assertions #(
  parameter int SW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs0N,
  input wire logic cs1,
  input wire logic wrN,
  input wire logic [11:0] busIn,
  input wire logic [SW-1:0] busOut,
  input wire logic busOe,
  input wire logic convValid,
  input wire logic convReady,
  input wire logic offsetZeroReq,
  input wire logic devResetPulse,
  input wire logic samplesReadyOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Command strobes and their causes
  dev_pulse_one_a: assert property (devResetPulse |=> !devResetPulse)
    else $error("device reset pulse too long");
  dev_pulse_cause_a: assert property ($rose(devResetPulse) |->
    $past(!wrN && busIn[11:10] == 2'h1 && busIn[0], 3))
    else $error("device reset pulse without command");
  rst_idle_a: assert property (devResetPulse |-> ##3 !samplesReadyOut && convReady)
    else $error("outputs not idle after device reset");
  ofs_cause_a: assert property ($rose(offsetZeroReq) |->
    $past(!wrN && busIn[8], 3))
    else $error("calibration without command");
  ofs_done_a: assert property (offsetZeroReq && convValid && convReady |->
    ##[1:3] !offsetZeroReq)
    else $error("calibration not ended by sample");
  // Read side never opened by a write or when deselected
  no_oe_write_a: assert property (!wrN [*4] |-> !busOe)
    else $error("output enabled during write");
  no_oe_idle_a: assert property ((cs0N || !cs1) [*4] |-> !busOe)
    else $error("output enabled while deselected");
  out_hold_a: assert property (!busOe |=> $stable(busOut))
    else $error("read data changed outside read");
endmodule

bind adcc_ctrl_one adcc_ctrl_one_assertions #(.SW(SW)) i_adcc_ctrl_one_assertions (
  .clk(clk), .rst(rst), .cs0N(cs0N), .cs1(cs1), .wrN(wrN), .busIn(busIn),
  .busOut(busOut), .busOe(busOe), .convValid(convValid), .convReady(convReady),
  .offsetZeroReq(offsetZeroReq), .devResetPulse(devResetPulse),
  .samplesReadyOut(samplesReadyOut));

// >>> tb/adcc_conv_model.sv
/*
  Sample source in place of the conversion pipeline, with its clock.
  Assumes go is a one-cycle request from the bench.
*/
`timescale 1ns/1ns

module adcc_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [9:0] value,
  input wire logic convReady,
  output logic convClk,
  output logic [9:0] convSample,
  output logic convValid
);
  logic [1:0] div;

  // Free running clock, offered sample held until taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      convClk <= 1'b0;
      convValid <= 1'b0;
      convSample <= 10'h000;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) begin
        convClk <= !convClk;
      end
      if (convValid && convReady) begin
        convValid <= 1'b0;
        convSample <= ~convSample; // No stale word after handoff
      end else if (go && !convValid) begin
        convValid <= 1'b1;
        convSample <= value;
      end
    end
  end
endmodule

// >>> tb/adcc_ctrl_one_tb.sv
/*
  Self-checking bench of the second control word block.
  Assumes the sample source model and the bound checker.
*/
`timescale 1ns/1ns

module adcc_ctrl_one_tb;
  logic clk, rst, cs0N, cs1, rdN, wrN, busOe, convClk, twoChannels, go, oeSeen;
  logic convValid, convReady, offsetZeroReq, devResetPulse, samplesReadyOut;
  logic [11:0] busIn;
  logic [9:0] busOut, convSample, value, v;
  logic [9:0] expQ[$];
  logic [9:0] sq[$];
  int miscompares = 0;
  int checks = 0;
  int seed = 3;
  int pw = 0;
  int lv[2][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}};

  adcc_ctrl_one i_adcc_ctrl_one (.clk(clk), .rst(rst), .cs0N(cs0N), .cs1(cs1),
    .rdN(rdN), .wrN(wrN), .busIn(busIn), .busOut(busOut), .busOe(busOe),
    .conversionClockIn(convClk), .twoChannels(twoChannels), .convSample(convSample),
    .convValid(convValid), .convReady(convReady), .offsetZeroReq(offsetZeroReq),
    .devResetPulse(devResetPulse), .samplesReadyOut(samplesReadyOut));
  adcc_conv_model i_adcc_conv_model (.clk(clk), .rst(rst), .go(go), .value(value),
    .convReady(convReady), .convClk(convClk), .convSample(convSample),
    .convValid(convValid));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Host write, word selected by 01 on top, reserved bit zero
  task automatic wr(input logic [11:0] w);
    @(negedge clk);
    cs0N = 1'b0;
    cs1 = 1'b1;
    busIn = w;
    wrN = 1'b0;
    repeat (6) @(negedge clk);
    wrN = 1'b1;
    cs0N = 1'b1;
    cs1 = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  // Host read, expected word noted for the monitor
  task automatic rd(input logic [9:0] e, input logic comb);
    expQ.push_back(e);
    @(negedge clk);
    cs0N = 1'b0;
    cs1 = 1'b1;
    rdN = comb;
    repeat (8) @(negedge clk);
    cs0N = 1'b1;
    rdN = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic send(input logic [9:0] s);
    int n;
    @(negedge clk);
    go = 1'b1;
    value = s;
    @(negedge clk);
    go = 1'b0;
    n = 0;
    while (convValid !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic rdy(input logic e);
    repeat (8) @(negedge clk);
    check("samplesReadyOut", {9'h0, e}, {9'h0, samplesReadyOut});
  endtask

  // Each finished read hands its word to the oldest note
  always @(negedge clk) begin
    if (oeSeen === 1'b1 && busOe === 1'b0) begin
      check("busOut", (expQ.size() > 0) ? expQ.pop_front() : ~busOut, busOut);
    end
    oeSeen = busOe;
  end

  initial begin
    #1_500_000;
    miscompares++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    cs0N = 1'b1;
    cs1 = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    busIn = 12'h000;
    twoChannels = 1'b0;
    go = 1'b0;
    value = 10'h000;
    oeSeen = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rdy(1'b0);
    check("convReady", 10'h001, {9'h0, convReady});
    repeat (40) @(negedge clk);
    // Every threshold code in both channel counts
    for (int c = 0; c < 2; c++) begin
      for (int t = 0; t < 4; t++) begin
        twoChannels = c[0];
        wr(12'h422 | {8'h00, t[1:0], 2'h0});
        for (int k = 1; k < lv[c][t]; k++) begin
          send(10'($random(seed)));
        end
        rdy(1'b0);
        send(10'($random(seed)));
        rdy(1'b1);
      end
    end
    wr(12'h42C);
    rdy(1'b1);
    wr(12'h40C);
    rdy(1'b0);
    wr(12'h40E);
    rdy(1'b1);
    // Level output drops on first read, rearms after four
    twoChannels = 1'b0;
    wr(12'h426);
    for (int k = 0; k < 4; k++) begin
      v = 10'($random(seed));
      sq.push_back(v);
      send(v);
    end
    rd(sq.pop_front() ^ 10'h200, 1'b0);
    rdy(1'b0);
    for (int k = 0; k < 3; k++) begin
      rd(sq.pop_front() ^ 10'h200, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      send(10'($random(seed)));
    end
    rdy(1'b1);
    // Binary format, then offset calibration with clamp
    wr(12'h4A2);
    v = 10'($random(seed));
    send(v);
    rd(v, 1'b0);
    wr(12'h5A2);
    send(10'h010);
    send(10'h100);
    rd(10'h0F0, 1'b0);
    send(10'h008);
    rd(10'h000, 1'b0);
    // Combined direction pin, then device reset through it
    wr(12'h4E2);
    send(10'h155);
    rd(10'h145, 1'b1);
    wr(12'h401);
    send(10'h3FF);
    repeat (40) @(negedge clk);
    send(10'h100);
    // Model conversion clock half period is three clocks
    pw = 0;
    repeat (16) begin
      @(negedge clk);
      pw += (samplesReadyOut === 1'b1) ? 1 : 0;
    end
    check("pulseWidth", 10'h003, 10'(pw));
    rdy(1'b0);
    rd(10'h300, 1'b0);
    rd(10'h300, 1'b0);
    finish_test();
  end
endmodule
